// ### src/sio_pkg.sv
// constants shared by the three-wire serial port files
`default_nettype none

package sio_pkg;

   // ==========================================================
   // register-file addresses and peripheral address
   localparam int         RF_ADDR_W     = 7;
   localparam logic [6:0] CTRL_ADDR     = 7'h22; // serial_control
   localparam logic [6:0] PORT_ADDR     = 7'h23; // port_enable_flag home
   localparam logic [6:0] IRQ_ADDR      = 7'h3B; // transfer_done_request
   localparam logic [6:0] SHIFT_PADDR   = 7'h01; // serial_shift_data

   // ==========================================================
   // field positions
   localparam int         CLK_SEL_LO_BIT = 0;   // clock_select_low
   localparam int         CLK_SEL_HI_BIT = 1;   // clock_select_high
   localparam int         FLOAT_BIT      = 2;   // output_float_control
   localparam int         START_BIT      = 3;   // transfer_start_flag
   localparam int         PORT_EN_BIT    = 0;   // port_enable_flag
   localparam int         IRQ_BIT        = 3;   // transfer_done_request

   // ==========================================================
   // reset values
   localparam logic [3:0] CTRL_RESET     = 4'h0;
   localparam logic [7:0] SHIFT_RESET    = 8'h00;

   // ==========================================================
   // clock selection codes and divider ratios
   localparam logic [1:0] SEL_EXT        = 2'h0;
   localparam logic [1:0] SEL_DIV16      = 2'h1;
   localparam logic [1:0] SEL_DIV128     = 2'h2;
   localparam logic [1:0] SEL_DIV1024    = 2'h3;
   localparam int         DIV16          = 16;
   localparam int         DIV128         = 128;
   localparam int         DIV1024        = 1024;
   localparam int         DIV_CNT_W      = 10;

   // ==========================================================
   // transfer length and fifo shape
   localparam int         BITS_PER_XFER  = 8;
   localparam int         BIT_CNT_W      = 3;
   localparam int         FIFO_DEPTH     = 8;

endpackage : sio_pkg

`default_nettype wire

// ### src/sio_fifo_if.sv
// valid/ready carrier between the port core and its receive fifo
`timescale 1ns/1ns
`default_nettype none

interface sio_fifo_if #(parameter int W = 8);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;

   // ==========================================================
   // core side fills and drains, fifo side stores
   modport core (output in_valid, output in_data, input in_ready,
                 input out_valid, input out_data, output out_ready);
   modport fifo (input in_valid, input in_data, output in_ready,
                 output out_valid, output out_data, input out_ready);
endinterface : sio_fifo_if

`default_nettype wire

// ### src/sio_fifo.sv
// receive fifo with registered output stage
`timescale 1ns/1ns
`default_nettype none

module sio_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   // stream
   sio_fifo_if.fifo  q
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic          out_valid_q;
   logic [W-1:0]  out_data_q;
   logic          push;
   logic          pop;

   // ==========================================================
   // handshakes
   assign q.in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign push        = q.in_valid && q.in_ready;
   assign pop         = (cnt_q != '0) && (!out_valid_q || q.out_ready);
   assign q.out_valid = out_valid_q;
   assign q.out_data  = out_data_q;

   // storage write
   always_ff @(posedge clk_i) begin
      if (ce_i && push) begin
         mem_q[wr_q] <= q.in_data;
      end
   end

   // pointers and fill count
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else if (ce_i) begin
         if (push) wr_q <= AW'(wr_q + 1'b1);
         if (pop)  rd_q <= AW'(rd_q + 1'b1);
         cnt_q <= (AW+1)'(cnt_q + push - pop);
      end
   end

   // output register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         out_valid_q <= 1'b0;
         out_data_q  <= '0;
      end else if (ce_i) begin
         if (pop) begin
            out_valid_q <= 1'b1;
            out_data_q  <= mem_q[rd_q];
         end else if (q.out_ready) begin
            out_valid_q <= 1'b0;
         end
      end
   end
endmodule : sio_fifo

`default_nettype wire

// ### src/sio_clkdiv.sv
// half-period tick generator for the internal serial clocks
`timescale 1ns/1ns
`default_nettype none

module sio_clkdiv
   import sio_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   // control
   input  wire logic       run_i,
   input  wire logic [1:0] sel_i,
   // tick each half serial period
   output logic            tick_o
);
   localparam logic [DIV_CNT_W-1:0] M16   = DIV_CNT_W'(DIV16 / 2 - 1);
   localparam logic [DIV_CNT_W-1:0] M128  = DIV_CNT_W'(DIV128 / 2 - 1);
   localparam logic [DIV_CNT_W-1:0] M1024 = DIV_CNT_W'(DIV1024 / 2 - 1);

   logic [DIV_CNT_W-1:0] cnt_q;
   logic [DIV_CNT_W-1:0] mask;

   // ==========================================================
   // ratio select
   always_comb begin
      case (sel_i)
         SEL_DIV16:   mask = M16;
         SEL_DIV128:  mask = M128;
         SEL_DIV1024: mask = M1024;
         default:     mask = M16;
      endcase
   end

   // restart while idle so the first half period is full length
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q  <= '0;
         tick_o <= 1'b0;
      end else if (ce_i) begin
         if (!run_i) begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
         end else begin
            tick_o <= ((cnt_q & mask) == mask);
            cnt_q  <= DIV_CNT_W'(cnt_q + 1'b1);
         end
      end
   end
endmodule : sio_clkdiv

`default_nettype wire

// ### src/sio_top.sv
// three-wire clocked serial port with receive fifo
`timescale 1ns/1ns
`default_nettype none

// Operation
// - falling clock edge drives shift msb out
// - rising clock edge shifts left, samples input
// - 3-bit counter, eighth pulse sets done flag
// - receive-only floats data output, still shifts
// - port enable off: pins free, no transfer
// - float bit chooses duplex or receive-only
// - end clears start flag, sets done flag
// - two-bit field selects clock source, divider
// - internal clock out only during transfer
// - external clock accepted only while started
// - setting start clears the done flag
// - writing start zero aborts, clears counter
// - start flag reads one while shifting
module sio_top #(
   parameter int DATA_W     = sio_pkg::BITS_PER_XFER,
   parameter int FIFO_DEPTH = sio_pkg::FIFO_DEPTH
) (
   // clock, reset, enable
   input  wire logic                        SYS_CLK_I,
   input  wire logic                        RST_I,
   input  wire logic                        CE_I,
   // register-file port
   input  wire logic [sio_pkg::RF_ADDR_W-1:0] RF_ADDR_I,
   input  wire logic                        RF_WE_I,
   input  wire logic                        RF_RE_I,
   input  wire logic [3:0]                  RF_WDATA_I,
   output logic      [3:0]                  RF_RDATA_O,
   // peripheral transfer through the data buffer
   input  wire logic                        PUT_I,
   input  wire logic [sio_pkg::RF_ADDR_W-1:0] PERIPH_ADDR_I,
   input  wire logic [DATA_W-1:0]           PUT_DATA_I,
   output logic      [DATA_W-1:0]           SHIFT_DATA_O,
   // serial pins
   input  wire logic                        SCK_I,
   output logic                             SCK_O,
   output logic                             SCK_OE_O,
   input  wire logic                        SI_I,
   output logic                             SO_O,
   output logic                             SO_OE_O,
   // received byte stream
   output logic                             RX_VALID_O,
   input  wire logic                        RX_READY_I,
   output logic      [DATA_W-1:0]           RX_DATA_O,
   // done flag to the interrupt controller
   output logic                             IRQ_REQ_O
);
   import sio_pkg::*;

   // ==========================================================
   // state
   // software-visible control bits
   logic [1:0]           clk_sel_q;    // clock_select_high/low
   logic                 float_q;      // output_float_control
   logic                 start_q;      // transfer_start_flag
   logic                 port_en_q;    // port_enable_flag
   logic                 irq_q;        // transfer_done_request

   // transfer progress
   logic [DATA_W-1:0]    shift_q;      // serial_shift_data
   logic [BIT_CNT_W-1:0] cnt_q;

   // pin drivers
   logic                 sck_q;
   logic                 sck_prev_q;
   logic                 sck_oe_q;
   logic                 so_q;
   logic                 so_oe_q;

   // read data
   logic [3:0]           rdata_q;

   // ==========================================================
   // decoded strobes and edges
   // register writes
   logic                 wr_ctrl;
   logic                 wr_port;
   logic                 wr_irq;

   // transfer control
   logic                 start_set;
   logic                 abort;
   logic                 internal;
   logic                 active;
   logic                 div_run;

   // serial clock events
   logic                 tick;
   logic                 fall;
   logic                 rise;

   // data path
   logic                 done;
   logic                 load;
   logic [DATA_W-1:0]    shift_next;

   sio_fifo_if #(.W(DATA_W)) rxq ();

   // register-file write decode
   assign wr_ctrl = RF_WE_I && (RF_ADDR_I == CTRL_ADDR);
   assign wr_port = RF_WE_I && (RF_ADDR_I == PORT_ADDR);
   assign wr_irq  = RF_WE_I && (RF_ADDR_I == IRQ_ADDR);

   // a start is refused while the fifo has no room for its byte
   assign start_set = wr_ctrl && RF_WDATA_I[START_BIT] && rxq.in_ready;
   assign abort     = wr_ctrl && !RF_WDATA_I[START_BIT];

   // clock source and shifting window
   assign internal = (clk_sel_q != SEL_EXT);
   assign active   = start_q && port_en_q;

   // divider and driven clock run only inside a transfer
   assign div_run  = active && internal;

   // serial clock edges from either source
   always_comb begin
      fall = 1'b0;
      rise = 1'b0;
      if (active) begin
         if (internal) begin
            // each divider tick flips the driven level
            fall = tick && sck_q;
            rise = tick && !sck_q;
         end else begin
            // edges of the sampled clock pin
            fall = sck_prev_q && !SCK_I;
            rise = !sck_prev_q && SCK_I;
         end
      end
   end

   // eighth rising edge closes the transfer
   assign done = rise && (cnt_q == BIT_CNT_W'(BITS_PER_XFER - 1));

   // byte as it stands after this rising edge
   assign shift_next = {shift_q[DATA_W-2:0], SI_I};

   // data-buffer load while no shifting is under way
   assign load = PUT_I && (PERIPH_ADDR_I == SHIFT_PADDR) && !active;

   // ==========================================================
   // internal serial clock divider
   sio_clkdiv u_div (
      .clk_i  (SYS_CLK_I),
      .rst_i  (RST_I),
      .ce_i   (CE_I),
      .run_i  (div_run),
      .sel_i  (clk_sel_q),
      .tick_o (tick)
   );

   // ==========================================================
   // receive fifo
   sio_fifo #(
      .W     (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i (SYS_CLK_I),
      .rst_i (RST_I),
      .ce_i  (CE_I),
      .q     (rxq.fifo)
   );

   // every completed byte is pushed; room was checked at start
   assign rxq.in_valid  = done;
   assign rxq.in_data   = shift_next;
   assign rxq.out_ready = RX_READY_I;

   // fifo output stage is already a register
   assign RX_VALID_O    = rxq.out_valid;
   assign RX_DATA_O     = rxq.out_data;

   // ==========================================================
   // control register fields other than start
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         clk_sel_q <= CTRL_RESET[CLK_SEL_HI_BIT:CLK_SEL_LO_BIT];
         float_q   <= CTRL_RESET[FLOAT_BIT];
      end else if (CE_I && wr_ctrl) begin
         clk_sel_q <= RF_WDATA_I[CLK_SEL_HI_BIT:CLK_SEL_LO_BIT];
         float_q   <= RF_WDATA_I[FLOAT_BIT];
      end
   end

   // port enable flag
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         port_en_q <= 1'b0;
      end else if (CE_I && wr_port) begin
         port_en_q <= RF_WDATA_I[PORT_EN_BIT];
      end
   end

   // ==========================================================
   // start flag: set by write, cleared by abort or end of byte
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         start_q <= CTRL_RESET[START_BIT];
      end else if (CE_I) begin
         // a new start outranks a finishing byte
         if (start_set) begin
            start_q <= 1'b1;
         end else if (abort || done) begin
            start_q <= 1'b0;
         end
      end
   end

   // done flag: hardware set wins over any clear
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         irq_q <= 1'b0;
      end else if (CE_I) begin
         if (done) begin
            irq_q <= 1'b1;
         end else if (start_set) begin
            irq_q <= 1'b0;
         end else if (wr_irq) begin
            // software may also set or clear it
            irq_q <= RF_WDATA_I[IRQ_BIT];
         end
      end
   end

   // bit counter, wraps to zero after the eighth pulse
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cnt_q <= '0;
      end else if (CE_I) begin
         // start and abort both restart the count
         if (start_set || abort) begin
            cnt_q <= '0;
         end else if (rise) begin
            cnt_q <= BIT_CNT_W'(cnt_q + 1'b1);
         end
      end
   end

   // ==========================================================
   // shift register: plain register when not shifting
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         shift_q <= SHIFT_RESET;
      end else if (CE_I) begin
         // a load only lands while idle
         if (load) begin
            shift_q <= PUT_DATA_I;
         end else if (rise) begin
            shift_q <= shift_next;
         end
      end
   end

   // ==========================================================
   // internal clock level, parked high outside a transfer
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         sck_q <= 1'b1;
      end else if (CE_I) begin
         if (!div_run) begin
            sck_q <= 1'b1;
         end else if (tick) begin
            sck_q <= !sck_q;
         end
      end
   end

   // last sampled external clock level for edge detection
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         sck_prev_q <= 1'b1;
      end else if (CE_I) begin
         // idle level is high, so no false edge
         sck_prev_q <= SCK_I;
      end
   end

   // data output bit follows the msb on each falling edge
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         so_q <= 1'b1;
      end else if (CE_I && fall) begin
         so_q <= shift_q[DATA_W-1];
      end
   end

   // clock pin drive, released when the port is off
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         sck_oe_q <= 1'b0;
      end else if (CE_I) begin
         sck_oe_q <= port_en_q && internal;
      end
   end

   // data pin drive, released in receive-only mode
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         so_oe_q  <= 1'b0;
      end else if (CE_I) begin
         so_oe_q  <= port_en_q && !float_q;
      end
   end

   // ==========================================================
   // register-file read data
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rdata_q <= 4'h0;
      end else if (CE_I && RF_RE_I) begin
         // unmapped addresses read as zero
         case (RF_ADDR_I)
            CTRL_ADDR: rdata_q <= {start_q, float_q, clk_sel_q};
            PORT_ADDR: rdata_q <= {3'h0, port_en_q};
            IRQ_ADDR:  rdata_q <= {irq_q, 3'h0};
            default:   rdata_q <= 4'h0;
         endcase
      end
   end

   // ==========================================================
   // outputs straight from flops: register side
   assign RF_RDATA_O   = rdata_q;
   assign SHIFT_DATA_O = shift_q;

   // serial pins
   assign SCK_O        = sck_q;
   assign SCK_OE_O     = sck_oe_q;
   assign SO_O         = so_q;
   assign SO_OE_O      = so_oe_q;

   // done flag
   assign IRQ_REQ_O    = irq_q;
endmodule : sio_top

`default_nettype wire

// ### testbench/sio_asserts.sv
// checker on the serial port top-level pins
`timescale 1ns/1ns
`default_nettype none
module sio_asserts
   import sio_pkg::*;
#(parameter int DATA_W = 8, parameter int FIFO_DEPTH = 8) (
   // clock, reset, enable
   input wire logic SYS_CLK_I, RST_I, CE_I,
   // register and peripheral port
   input wire logic [RF_ADDR_W-1:0] RF_ADDR_I, PERIPH_ADDR_I,
   input wire logic RF_WE_I, RF_RE_I, PUT_I,
   input wire logic [3:0] RF_WDATA_I, RF_RDATA_O,
   input wire logic [DATA_W-1:0] PUT_DATA_I, SHIFT_DATA_O, RX_DATA_O,
   // pins and stream
   input wire logic SCK_I, SCK_O, SCK_OE_O, SI_I, SO_O, SO_OE_O,
   input wire logic RX_VALID_O, RX_READY_I, IRQ_REQ_O
);
   // ==========================================================
   // shadow of software bits, rise and fifo counters
   logic       pen_q, flt_q;
   logic [1:0] sel_q;
   logic [3:0] stab_q, rise_q, occ_q;
   wire wr_c = CE_I && RF_WE_I && RF_ADDR_I == CTRL_ADDR;
   wire wr_p = CE_I && RF_WE_I && RF_ADDR_I == PORT_ADDR;

   // software-written control bits
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         pen_q  <= 1'h0;
         flt_q  <= 1'h0;
         sel_q  <= 2'h0;
         stab_q <= 4'h0;
      end else begin
         if (wr_c) {flt_q, sel_q} <= RF_WDATA_I[2:0];
         if (wr_p) pen_q <= RF_WDATA_I[PORT_EN_BIT];
         if (wr_c || wr_p) stab_q <= 4'h0;
         else if (stab_q != 4'hF) stab_q <= stab_q + 4'h1;
      end
   end

   // serial clock rises since the last control write, bytes held in fifo
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rise_q <= 4'h0;
         occ_q  <= 4'h0;
      end else begin
         if (wr_c) rise_q <= 4'h0;
         else if ($rose(SCK_O)) rise_q <= rise_q + 4'h1;
         occ_q <= occ_q + 4'($rose(IRQ_REQ_O))
                  - 4'(RX_VALID_O && RX_READY_I);
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);

   a_reset_idle:
      assert property ($fell(RST_I) |-> SCK_O && !SCK_OE_O && !SO_OE_O
         && !IRQ_REQ_O && SHIFT_DATA_O == 8'h00)
      else $error("outputs not idle after reset");
   a_so_float:
      assert property (stab_q > 4'h2 |-> SO_OE_O == (pen_q && !flt_q))
      else $error("data out enable wrong");
   a_sck_drive:
      assert property (stab_q > 4'h2
         |-> SCK_OE_O == (pen_q && sel_q != SEL_EXT))
      else $error("clock pin enable wrong");
   a_idle_high:
      assert property ($rose(IRQ_REQ_O) |-> SCK_O [*4])
      else $error("clock not high after frame");
   a_msb_out:
      assert property ($fell(SCK_O) && SO_OE_O |=> SO_O == SHIFT_DATA_O[7])
      else $error("data out is not shift msb");
   a_shift_in:
      assert property ($rose(SCK_O) && !$past(RF_WE_I)
         && !$past(RF_WE_I, 2) |-> SHIFT_DATA_O
         == DATA_W'({$past(SHIFT_DATA_O), $past(SI_I)}))
      else $error("shift on rise wrong");
   a_done_count:
      assert property ($rose(IRQ_REQ_O) && sel_q != SEL_EXT
         |=> rise_q == 4'h8)
      else $error("done flag not after eight pulses");
   a_start_clear:
      assert property (wr_c && RF_WDATA_I[START_BIT] && occ_q < 4'h7
         |-> ##[1:2] !IRQ_REQ_O)
      else $error("start did not clear done flag");
   a_abort_quiet:
      assert property (wr_c && !RF_WDATA_I[START_BIT]
         |-> ##1 !$rose(IRQ_REQ_O) [*8])
      else $error("done flag after abort");

   c_slow_done: cover property ($rose(IRQ_REQ_O) && sel_q == SEL_DIV1024);
   c_float: cover property (SCK_OE_O && !SO_OE_O && !SCK_O);
   c_full: cover property (occ_q >= 4'(FIFO_DEPTH));
endmodule : sio_asserts

bind sio_top sio_asserts #(.DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH))
   sio_asserts_i (.*);
`default_nettype wire

// ### testbench/sio_peer.sv
// far-side serial partner: data lines and external clock
`timescale 1ns/1ns
`default_nettype none
module sio_peer (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // pins and control
   input  wire logic       sck_i,
   input  wire logic       so_i,
   input  wire logic       ld_i,
   input  wire logic [7:0] tx_i,
   input  wire logic       go_i,
   output logic            sck_o,
   output logic            si_o,
   output logic [7:0]      rx_o
);
   logic [7:0] tx_q;
   logic [3:0] n_q;
   logic       sck_q;
   logic [5:0] t_q;

   // next bit on fall, capture on rise, data line inverted after 8
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         {tx_q, rx_o, n_q, si_o} <= '0;
         sck_q <= 1'h1;
      end else begin
         sck_q <= sck_i;
         if (ld_i) begin
            tx_q <= tx_i;
            n_q  <= 4'h0;
         end else if (sck_q && !sck_i) begin
            si_o <= tx_q[7];
            tx_q <= tx_q << 1;
         end else if (!sck_q && sck_i) begin
            rx_o <= {rx_o[6:0], so_i};
            n_q  <= n_q + 4'h1;
            if (n_q == 4'h7) si_o <= !si_o;
         end
      end
   end

   // external clock frame: 8 pulses, idle high
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         t_q   <= 6'h00;
         sck_o <= 1'h1;
      end else begin
         if (go_i && t_q == 6'h00) t_q <= 6'h01;
         else if (t_q != 6'h00) t_q <= t_q + 6'h01;
         sck_o <= t_q == 6'h00 || t_q[2];
      end
   end
endmodule : sio_peer
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the three-wire serial port
`timescale 1ns/1ns
`default_nettype none
module tb;
   import sio_pkg::*;
   logic SYS_CLK_I = 1'h0, RST_I = 1'h0, CE_I = 1'h1, RF_WE_I = 1'h0;
   logic RF_RE_I = 1'h0, PUT_I = 1'h0, RX_READY_I = 1'h0;
   logic [6:0] RF_ADDR_I = 7'h00, PERIPH_ADDR_I = 7'h00;
   logic [3:0] RF_WDATA_I = 4'h0, RF_RDATA_O, v;
   logic [7:0] PUT_DATA_I = 8'h00, SHIFT_DATA_O, RX_DATA_O, prx;
   logic [7:0] ptx = 8'h00;
   logic SCK_I, SCK_O, SCK_OE_O, SI_I, SO_O, SO_OE_O, RX_VALID_O;
   logic IRQ_REQ_O, sck_ext, ld = 1'h0, go = 1'h0;
   int n_errors = 0, samples_checked = 0;
   logic [7:0] expq[$];

   sio_top sio_top_i (.*);
   sio_peer sio_peer_i (.clk_i(SYS_CLK_I), .rst_i(RST_I), .sck_i(SCK_I),
      .so_i(SO_OE_O ? SO_O : !SO_O), .ld_i(ld), .tx_i(ptx), .go_i(go),
      .sck_o(sck_ext), .si_o(SI_I), .rx_o(prx));
   assign SCK_I = SCK_OE_O ? SCK_O : sck_ext;

   initial forever #5 SYS_CLK_I = ~SYS_CLK_I;

   task automatic tick();
      @(posedge SYS_CLK_I) #1;
   endtask : tick

   task automatic chk(input logic [7:0] got, exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [6:0] a, input logic [3:0] d);
      tick();
      RF_ADDR_I = a;
      RF_WDATA_I = d;
      RF_WE_I = 1'h1;
      @(posedge SYS_CLK_I) #1 RF_WE_I = 1'h0;
   endtask : wr

   task automatic rd(input logic [6:0] a);
      tick();
      RF_ADDR_I = a;
      RF_RE_I = 1'h1;
      @(posedge SYS_CLK_I) #1 RF_RE_I = 1'h0;
      tick();
      v = RF_RDATA_O;
   endtask : rd

   task automatic put(input logic [7:0] d);
      tick();
      PERIPH_ADDR_I = SHIFT_PADDR;
      PUT_DATA_I = d;
      PUT_I = 1'h1;
      @(posedge SYS_CLK_I) #1 PUT_I = 1'h0;
   endtask : put

   task automatic load(input logic [7:0] s);
      ptx = s;
      ld = 1'h1;
      tick();
      ld = 1'h0;
   endtask : load

   task automatic wait_irq();
      for (int i = 0; i < 20000 && IRQ_REQ_O !== 1'h1; i++) tick();
      chk(IRQ_REQ_O, 1'h1, "done flag");
   endtask : wait_irq

   // one whole frame; checks data shifted in, and data shifted out unless the float bit is set
   task automatic xfer(input logic [3:0] c, input logic [7:0] t, s);
      wr(CTRL_ADDR, c);
      put(t);
      load(s);
      wr(CTRL_ADDR, c | 4'h8);
      rd(IRQ_ADDR);
      chk(v, 4'h0, "done after start");
      rd(CTRL_ADDR);
      chk(v, c | 4'h8, "start while busy");
      if (c[1:0] == SEL_EXT) begin
         go = 1'h1;
         tick();
         go = 1'h0;
      end
      wait_irq();
      rd(CTRL_ADDR);
      chk(v, c, "start after frame");
      rd(IRQ_ADDR);
      chk(v, 4'h8, "done readback");
      chk(SHIFT_DATA_O, s, "shifted in");
      if (!c[2]) chk(prx, t, "shifted out");
      expq.push_back(s);
   endtask : xfer

   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out

   initial begin
      #1_000_000;
      n_errors++;
      close_out();
   end

   initial begin
      RST_I = 1'h1;
      repeat (4) @(posedge SYS_CLK_I);
      #1 RST_I = 1'h0;
      rd(CTRL_ADDR);
      chk(v, CTRL_RESET, "control reset");
      chk(SHIFT_DATA_O, SHIFT_RESET, "shift reset");
      chk({SCK_O, SCK_OE_O, SO_OE_O}, 3'h4, "pins reset");
      $display("test reset done");
      wr(CTRL_ADDR, 4'h1);
      wr(CTRL_ADDR, 4'h9);
      repeat (40) tick();
      chk({SCK_OE_O, IRQ_REQ_O}, 2'h0, "port off");
      wr(CTRL_ADDR, 4'h1);
      wr(PORT_ADDR, 4'h1);
      $display("test port off done");
      for (int i = 1; i < 4; i++) xfer(4'(i), 8'hA5 ^ 8'(i), 8'h3C + 8'(i));
      xfer(4'h5, 8'h0F, 8'h81);
      chk(SO_OE_O, 1'h0, "data out floats");
      wr(CTRL_ADDR, 4'h0);
      put(8'hC3);
      go = 1'h1;
      tick();
      go = 1'h0;
      repeat (70) tick();
      chk(SHIFT_DATA_O, 8'hC3, "pulses while stopped");
      xfer(4'h0, 8'h96, 8'h5A);
      $display("test frames done");
      wr(CTRL_ADDR, 4'h2);
      wr(CTRL_ADDR, 4'hA);
      repeat (200) tick();
      wr(CTRL_ADDR, 4'h2);
      repeat (1200) tick();
      rd(CTRL_ADDR);
      chk({IRQ_REQ_O, v}, 5'h02, "abort");
      $display("test abort done");
      wr(CTRL_ADDR, 4'h1);
      for (int i = 0; i < 12; i++) begin
         load(8'h10 + 8'(i));
         wr(CTRL_ADDR, 4'h9);
         rd(CTRL_ADDR);
         if (v[3] !== 1'h1) break;
         wait_irq();
         expq.push_back(8'h10 + 8'(i));
      end
      chk(v, 4'h1, "start refused when full");
      chk(expq.size() >= FIFO_DEPTH, 1'h1, "fifo depth");
      for (int k = 0; k < 400 && expq.size() > 0; k++) begin
         RX_READY_I = k[1];
         if (RX_VALID_O && RX_READY_I)
            chk(RX_DATA_O, expq.pop_front(), "fifo data");
         tick();
      end
      chk(8'(expq.size()), 8'h00, "fifo drained");
      chk(RX_VALID_O, 1'h0, "fifo valid after drain");
      $display("test fifo done");
      close_out();
   end
endmodule : tb
`default_nettype wire
